/* src/tcu_pkg.sv */
package tcu_pkg;

	// Counter width and the named count values.
	localparam int         TCU_W      = 8;
	localparam logic [7:0] TCU_BOTTOM = 8'h00;
	localparam logic [7:0] TCU_MAX    = 8'hFF;
	localparam logic [7:0] TCU_ONE    = 8'h01;
	localparam logic [7:0] TCU_RST8   = 8'h00;

	// Clock source select codes: stop, prescaled system clock, external pin.
	typedef enum logic [2:0] {
		TCU_CS_STOP     = 3'h0,
		TCU_CS_DIV1     = 3'h1,
		TCU_CS_DIV8     = 3'h2,
		TCU_CS_DIV64    = 3'h3,
		TCU_CS_DIV256   = 3'h4,
		TCU_CS_DIV1024  = 3'h5,
		TCU_CS_EXT_FALL = 3'h6,
		TCU_CS_EXT_RISE = 3'h7
	} tcu_cs_t;

	// Waveform modes; codes 4 and 6 are reserved and count as normal mode.
	typedef enum logic [2:0] {
		TCU_WGM_NORMAL    = 3'h0,
		TCU_WGM_PC_MAX    = 3'h1,
		TCU_WGM_CTC       = 3'h2,
		TCU_WGM_FAST_MAX  = 3'h3,
		TCU_WGM_RSVD4     = 3'h4,
		TCU_WGM_PC_OCRA   = 3'h5,
		TCU_WGM_RSVD6     = 3'h6,
		TCU_WGM_FAST_OCRA = 3'h7
	} tcu_wgm_t;

	// Count direction, used by the phase correct modes only.
	typedef enum logic {
		TCU_DIR_UP   = 1'b0,
		TCU_DIR_DOWN = 1'b1
	} tcu_dir_t;

	// Prescaler width and the all-ones masks that mark each divided tick.
	localparam int          TCU_PRE_W     = 10;
	localparam logic [9:0]  TCU_PRE_RST   = 10'h000;
	localparam logic [9:0]  TCU_PRE_M8    = 10'h007;
	localparam logic [9:0]  TCU_PRE_M64   = 10'h03F;
	localparam logic [9:0]  TCU_PRE_M256  = 10'h0FF;
	localparam logic [9:0]  TCU_PRE_M1024 = 10'h3FF;
	localparam logic [9:0]  TCU_PRE_INC   = 10'h001;
	localparam int          TCU_SYNC_N    = 3;

	// Field positions in the control, flag and mask bytes.
	localparam int TCU_CA_WGM_LO = 0;
	localparam int TCU_CA_WGM_W  = 2;
	localparam int TCU_CB_CS_LO  = 0;
	localparam int TCU_CB_CS_W   = 3;
	localparam int TCU_CB_WGM2   = 3;
	localparam int TCU_WGM_HI    = 2;
	localparam int TCU_FL_OV     = 0;
	localparam int TCU_FL_CMPA   = 1;
	localparam int TCU_FL_CMPB   = 2;
	localparam int TCU_NIRQ      = 3;
	localparam int TCU_NCH       = 2;
	localparam logic [2:0] TCU_IRQ_NONE = 3'h0;

	// One processor write: a strobe per target and the shared data byte.
	typedef struct packed {
		logic       count;
		logic       cmp_a;
		logic       cmp_b;
		logic       ctrl_a;
		logic       ctrl_b;
		logic       mask;
		logic       flag;
		logic [7:0] data;
	} tcu_cpu_wr_t;

	// Counter indications toward the waveform generator.
	typedef struct packed {
		logic top_hit;
		logic bottom_hit;
		logic match_a;
		logic match_b;
	} tcu_ind_t;

endpackage : tcu_pkg

/* src/tcu_clock_select.sv */
`timescale 1ns/1ps
// Turns the clock source select code into a one-cycle timer tick.
module tcu_clock_select (
	input  wire logic              clk,                  // System clock.
	input  wire logic              nrst,                 // Async reset, low.
	input  wire tcu_pkg::tcu_cs_t  clock_source_select,  // Source and edge.
	input  wire logic              external_count_input, // Pin, async.
	output logic                   timer_tick            // One-cycle tick.
);

	logic [tcu_pkg::TCU_PRE_W-1:0]  pre;
	logic [tcu_pkg::TCU_SYNC_N-1:0] sync;
	logic                           ext_lvl;
	logic                           ext_rise;
	logic                           ext_fall;
	logic                           next_tick;

	// Free-running prescaler; it is never reset by a source change.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pre <= tcu_pkg::TCU_PRE_RST;
		end else begin
			pre <= pre + tcu_pkg::TCU_PRE_INC;
		end
	end

	// Three-stage synchroniser; the first stage feeds only the second.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync <= '0;
		end else begin
			sync <= {sync[tcu_pkg::TCU_SYNC_N-2:0], external_count_input};
		end
	end

	// The pin level is accepted only once stages two and three agree.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_lvl <= 1'b0;
		end else if (sync[1] == sync[2]) begin
			ext_lvl <= sync[2];
		end
	end

	assign ext_rise = (sync[1] == sync[2]) && sync[2] && !ext_lvl;
	assign ext_fall = (sync[1] == sync[2]) && !sync[2] && ext_lvl;

	// Source and edge choice; stop yields no tick at all.
	always_comb begin
		case (clock_source_select)
			tcu_pkg::TCU_CS_STOP:     next_tick = 1'b0;
			tcu_pkg::TCU_CS_DIV1:     next_tick = 1'b1;
			tcu_pkg::TCU_CS_DIV8:
				next_tick = (pre & tcu_pkg::TCU_PRE_M8) == tcu_pkg::TCU_PRE_M8;
			tcu_pkg::TCU_CS_DIV64:
				next_tick = (pre & tcu_pkg::TCU_PRE_M64) == tcu_pkg::TCU_PRE_M64;
			tcu_pkg::TCU_CS_DIV256:
				next_tick = (pre & tcu_pkg::TCU_PRE_M256)
					== tcu_pkg::TCU_PRE_M256;
			tcu_pkg::TCU_CS_DIV1024:  next_tick = pre == tcu_pkg::TCU_PRE_M1024;
			tcu_pkg::TCU_CS_EXT_FALL: next_tick = ext_fall;
			default:                  next_tick = ext_rise;
		endcase
	end

	// Registered so the counter sees a clean single-cycle pulse.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			timer_tick <= 1'b0;
		end else begin
			timer_tick <= next_tick;
		end
	end

endmodule : tcu_clock_select

/* src/tcu_timer0_counter.sv */
// Operation
// - Count and both compare values are 8-bit processor read/write registers.
// - Every request shows as a flag bit, gated by its own mask bit.
// - Three interrupt sources: overflow, compare match A, compare match B.
// - Tick from prescaler or external input; select picks source and edge.
// - Clock source select zero stops the counter completely.
// - Each tick clears, increments or decrements the count per waveform mode.
// - Count steps by exactly one up or down; clear zeroes all bits.
// - Top indication at sequence maximum, bottom indication at zero.
// - Count 0x00 is BOTTOM and 0xFF is MAX.
// - TOP is 0xFF or compare value A, depending on mode.
// - Processor may read and write the count at any time.
// - A processor count write beats a simultaneous clear or count.
// - Three-bit waveform mode: two bits in control A, one in control B.
// - Both compares are checked against the count always; matches go out.
// - A compare match sets its channel flag, which may request an interrupt.
// - Overflow flag is set per waveform mode and may request an interrupt.
// - Compare registers are double buffered against arbitrary-time updates.
// - Compare flag sets a tick after match; service or write-one clears it.
// - Buffering only in PWM modes, loaded at top, never at bottom; else direct.
// - Mode zero counts up, wraps 0xFF to 0x00, sets overflow as it wraps.
`timescale 1ns/1ps
module tcu_timer0_counter (
	input  wire logic                        clk,                  // Clock.
	input  wire logic                        nrst,                 // Reset, low.
	input  wire tcu_pkg::tcu_cpu_wr_t        cpu_wr,               // Writes.
	input  wire logic [tcu_pkg::TCU_NIRQ-1:0] irq_ack,             // Serviced.
	input  wire logic                        external_count_input, // Pin.
	output logic [tcu_pkg::TCU_W-1:0]        count_value,          // Count.
	output logic [tcu_pkg::TCU_W-1:0]        compare_value_a,      // Buffer A.
	output logic [tcu_pkg::TCU_W-1:0]        compare_value_b,      // Buffer B.
	output logic [tcu_pkg::TCU_W-1:0]        timer_control_a,      // Readback.
	output logic [tcu_pkg::TCU_W-1:0]        timer_control_b,      // Readback.
	output logic [tcu_pkg::TCU_W-1:0]        timer_flag_register,  // Flags.
	output logic [tcu_pkg::TCU_W-1:0]        timer_mask_register,  // Masks.
	output logic [tcu_pkg::TCU_NIRQ-1:0]     irq_req,              // Requests.
	output tcu_pkg::tcu_ind_t                ind                   // To wavegen.
);

	// Mode helpers shared by the counter and the compare buffers.
	// Reserved codes fall in neither set and so behave as normal mode.
	function automatic logic is_pwm(input tcu_pkg::tcu_wgm_t m);
		is_pwm = (m == tcu_pkg::TCU_WGM_PC_MAX)
			|| (m == tcu_pkg::TCU_WGM_FAST_MAX)
			|| (m == tcu_pkg::TCU_WGM_PC_OCRA)
			|| (m == tcu_pkg::TCU_WGM_FAST_OCRA);
	endfunction : is_pwm

	function automatic logic top_is_cmp_a(input tcu_pkg::tcu_wgm_t m);
		top_is_cmp_a = (m == tcu_pkg::TCU_WGM_CTC)
			|| (m == tcu_pkg::TCU_WGM_PC_OCRA)
			|| (m == tcu_pkg::TCU_WGM_FAST_OCRA);
	endfunction : top_is_cmp_a

	tcu_pkg::tcu_wgm_t               wgm;
	tcu_pkg::tcu_wgm_t               next_wgm;
	tcu_pkg::tcu_cs_t                cs;
	tcu_pkg::tcu_dir_t               dir;
	tcu_pkg::tcu_dir_t               next_dir;
	logic [tcu_pkg::TCU_W-1:0]       count;
	logic [tcu_pkg::TCU_W-1:0]       next_count;
	logic [tcu_pkg::TCU_W-1:0]       count_d;
	logic [tcu_pkg::TCU_W-1:0]       top_val;
	logic [tcu_pkg::TCU_W-1:0]       cmp_buf [tcu_pkg::TCU_NCH];
	logic [tcu_pkg::TCU_W-1:0]       cmp_act [tcu_pkg::TCU_NCH];
	logic [tcu_pkg::TCU_NCH-1:0]     cmp_wr;
	logic [tcu_pkg::TCU_NCH-1:0]     match;
	logic [tcu_pkg::TCU_NIRQ-1:0]    flags;
	logic [tcu_pkg::TCU_NIRQ-1:0]    mask;
	logic [tcu_pkg::TCU_NIRQ-1:0]    flag_set;
	logic [tcu_pkg::TCU_NIRQ-1:0]    flag_clr;
	logic                            tick;
	logic                            ov_evt;
	logic                            upd_evt;
	logic                            block;

	// Tick generation; a stopped source never produces a tick.
	tcu_clock_select u_clock_select (
		.clk                  (clk),
		.nrst                 (nrst),
		.clock_source_select  (cs),
		.external_count_input (external_count_input),
		.timer_tick           (tick)
	);

	// Mode bits gathered from both control bytes. Each byte may be written
	// alone, so the half it does not hold keeps its old value; the whole
	// enum is stored at once rather than through a part-select.
	always_comb begin
		next_wgm = wgm;
		if (cpu_wr.ctrl_a) begin
			next_wgm = tcu_pkg::tcu_wgm_t'({wgm[tcu_pkg::TCU_WGM_HI],
				cpu_wr.data[tcu_pkg::TCU_CA_WGM_LO +: tcu_pkg::TCU_CA_WGM_W]});
		end
		if (cpu_wr.ctrl_b) begin
			next_wgm = tcu_pkg::tcu_wgm_t'({cpu_wr.data[tcu_pkg::TCU_CB_WGM2],
				next_wgm[tcu_pkg::TCU_CA_WGM_W-1:0]});
		end
	end

	// Control fields; a mode change takes effect from the next tick on.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wgm <= tcu_pkg::TCU_WGM_NORMAL;
			cs  <= tcu_pkg::TCU_CS_STOP;
		end else begin
			if (cpu_wr.ctrl_a || cpu_wr.ctrl_b) begin
				wgm <= next_wgm;
			end
			if (cpu_wr.ctrl_b) begin
				cs <= tcu_pkg::tcu_cs_t'(
					cpu_wr.data[tcu_pkg::TCU_CB_CS_LO +: tcu_pkg::TCU_CB_CS_W]);
			end
		end
	end

	// Control readback with unused bits at zero.
	always_comb begin
		timer_control_a = '0;
		timer_control_b = '0;
		timer_control_a[tcu_pkg::TCU_CA_WGM_LO +: tcu_pkg::TCU_CA_WGM_W] =
			wgm[tcu_pkg::TCU_CA_WGM_W-1:0];
		timer_control_b[tcu_pkg::TCU_CB_CS_LO +: tcu_pkg::TCU_CB_CS_W] = cs;
		timer_control_b[tcu_pkg::TCU_CB_WGM2] = wgm[tcu_pkg::TCU_WGM_HI];
	end

	// TOP follows compare A in the modes that use it, else the fixed MAX.
	// With TOP at MAX, a compare A write leaves the period untouched.
	assign top_val = top_is_cmp_a(wgm) ? cmp_act[0] : tcu_pkg::TCU_MAX;

	// Next count per mode. Reserved modes behave as normal mode so that a
	// stray code still gives a predictable free-running counter.
	always_comb begin
		next_count = count;
		next_dir   = dir;
		ov_evt     = 1'b0;
		upd_evt    = 1'b0;
		if (tick) begin
			case (wgm)
				tcu_pkg::TCU_WGM_PC_MAX, tcu_pkg::TCU_WGM_PC_OCRA: begin
					if (dir == tcu_pkg::TCU_DIR_UP) begin
						if (count == top_val) begin
							next_dir   = tcu_pkg::TCU_DIR_DOWN;
							next_count = count - tcu_pkg::TCU_ONE;
							upd_evt    = 1'b1;
						end else begin
							next_count = count + tcu_pkg::TCU_ONE;
						end
					end else if (count == tcu_pkg::TCU_BOTTOM) begin
						next_dir   = tcu_pkg::TCU_DIR_UP;
						next_count = count + tcu_pkg::TCU_ONE;
						ov_evt     = 1'b1;
					end else begin
						next_count = count - tcu_pkg::TCU_ONE;
					end
				end
				tcu_pkg::TCU_WGM_CTC: begin
					next_dir = tcu_pkg::TCU_DIR_UP;
					if (count == top_val) begin
						next_count = tcu_pkg::TCU_BOTTOM;
					end else begin
						next_count = count + tcu_pkg::TCU_ONE;
					end
					ov_evt = count == tcu_pkg::TCU_MAX;
				end
				tcu_pkg::TCU_WGM_FAST_MAX, tcu_pkg::TCU_WGM_FAST_OCRA: begin
					next_dir = tcu_pkg::TCU_DIR_UP;
					if (count == top_val) begin
						next_count = tcu_pkg::TCU_BOTTOM;
						ov_evt     = 1'b1;
						upd_evt    = 1'b1;
					end else begin
						next_count = count + tcu_pkg::TCU_ONE;
					end
				end
				default: begin
					next_dir   = tcu_pkg::TCU_DIR_UP;
					next_count = count + tcu_pkg::TCU_ONE;
					ov_evt     = count == tcu_pkg::TCU_MAX;
				end
			endcase
		end
	end

	// A processor write takes precedence over any count or clear.
	// This also lets software restart a running timer without stopping it.
	assign count_d = cpu_wr.count ? cpu_wr.data : next_count;

	// Count register, reachable at any time, stopped or running.
	// Direction is only used by the phase correct modes; every other mode
	// forces it up on each tick, so a switch into phase correct starts upward
	// once the other mode has ticked at least once.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= tcu_pkg::TCU_RST8;
			dir   <= tcu_pkg::TCU_DIR_UP;
		end else begin
			count <= count_d;
			dir   <= next_dir;
		end
	end

	assign count_value = count;

	// A count write suppresses matches until the next tick has passed, so a
	// compare may be preset equal to the count without a false flag.
	// A write in a tick cycle blocks the match of the following tick.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			block <= 1'b0;
		end else if (cpu_wr.count) begin
			block <= 1'b1;
		end else if (tick) begin
			block <= 1'b0;
		end
	end

	// Compare write strobes, channel A in bit zero to match the index.
	assign cmp_wr = {cpu_wr.cmp_b, cpu_wr.cmp_a};

	// Per channel: processor buffer, active compare value and comparator.
	for (genvar ch = 0; ch < tcu_pkg::TCU_NCH; ch++) begin : g_ch
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				cmp_buf[ch] <= tcu_pkg::TCU_RST8;
			end else if (cmp_wr[ch]) begin
				cmp_buf[ch] <= cpu_wr.data;
			end
		end

		// PWM modes load the comparator only at the update point, which
		// avoids odd-length pulses; other modes track the write at once.
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				cmp_act[ch] <= tcu_pkg::TCU_RST8;
			end else if (!is_pwm(wgm)) begin
				cmp_act[ch] <= cmp_wr[ch] ? cpu_wr.data : cmp_buf[ch];
			end else if (upd_evt) begin
				cmp_act[ch] <= cmp_buf[ch];
			end
		end

		assign match[ch] = count == cmp_act[ch];
	end

	assign compare_value_a = cmp_buf[0];
	assign compare_value_b = cmp_buf[1];

	// Flag sources: a match held during a tick period sets its flag on
	// the closing tick; overflow is set with the wrapping tick.
	always_comb begin
		flag_set = tcu_pkg::TCU_IRQ_NONE;
		flag_set[tcu_pkg::TCU_FL_OV]   = ov_evt;
		flag_set[tcu_pkg::TCU_FL_CMPA] = tick && match[0] && !block;
		flag_set[tcu_pkg::TCU_FL_CMPB] = tick && match[1] && !block;
	end

	// Clears come from write-one or from interrupt service.
	// Both sources may hit different bits in one cycle; they simply merge.
	assign flag_clr = (cpu_wr.flag ? cpu_wr.data[tcu_pkg::TCU_NIRQ-1:0]
		: tcu_pkg::TCU_IRQ_NONE) | irq_ack;

	// Set beats a clear in the same cycle so no event is lost.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flags <= tcu_pkg::TCU_IRQ_NONE;
		end else begin
			flags <= (flags & ~flag_clr) | flag_set;
		end
	end

	// Mask register. Masking only gates the request; the flag itself keeps
	// recording events, so unmasking later shows what happened meanwhile.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mask <= tcu_pkg::TCU_IRQ_NONE;
		end else if (cpu_wr.mask) begin
			mask <= cpu_wr.data[tcu_pkg::TCU_NIRQ-1:0];
		end
	end

	// Status bytes and the gated requests.
	always_comb begin
		timer_flag_register = '0;
		timer_mask_register = '0;
		timer_flag_register[tcu_pkg::TCU_NIRQ-1:0] = flags;
		timer_mask_register[tcu_pkg::TCU_NIRQ-1:0] = mask;
	end

	assign irq_req = flags & mask;

	// Indications for the waveform generator, registered from the next
	// count so they line up with the count they describe.
	// The match pulses repeat the flag set, so they never fire while blocked.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ind <= '0;
		end else begin
			ind.top_hit    <= count_d == top_val;
			ind.bottom_hit <= count_d == tcu_pkg::TCU_BOTTOM;
			ind.match_a    <= flag_set[tcu_pkg::TCU_FL_CMPA];
			ind.match_b    <= flag_set[tcu_pkg::TCU_FL_CMPB];
		end
	end

endmodule : tcu_timer0_counter

/* sim/tcu_timer0_counter_checker.sv */
`timescale 1ns/1ps
// Watches the counter core's ports for write, flag and counting relations.
module tcu_timer0_counter_checker (
	input wire logic                         clk,                  // Clock.
	input wire logic                         nrst,                 // Reset.
	input wire tcu_pkg::tcu_cpu_wr_t         cpu_wr,               // Writes.
	input wire logic [tcu_pkg::TCU_NIRQ-1:0] irq_ack,              // Service.
	input wire logic                         external_count_input, // Pin.
	input wire logic [tcu_pkg::TCU_W-1:0]    count_value,          // Count.
	input wire logic [tcu_pkg::TCU_W-1:0]    compare_value_a,      // Cmp A.
	input wire logic [tcu_pkg::TCU_W-1:0]    compare_value_b,      // Cmp B.
	input wire logic [tcu_pkg::TCU_W-1:0]    timer_control_a,      // Ctrl A.
	input wire logic [tcu_pkg::TCU_W-1:0]    timer_control_b,      // Ctrl B.
	input wire logic [tcu_pkg::TCU_W-1:0]    timer_flag_register,  // Flags.
	input wire logic [tcu_pkg::TCU_W-1:0]    timer_mask_register,  // Masks.
	input wire logic [tcu_pkg::TCU_NIRQ-1:0] irq_req,              // Requests.
	input wire tcu_pkg::tcu_ind_t            ind                   // Wavegen.
);
	logic [1:0] cs_hist;
	logic       stopped;
	logic       normal;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// Stopped needs three idle cycles, so a tick decoded earlier is gone.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cs_hist <= 2'h0;
		end else begin
			cs_hist <= {cs_hist[0], timer_control_b[2:0] == 3'h0};
		end
	end

	// Plain normal mode only; reserved codes are left out on purpose.
	assign stopped = (timer_control_b[2:0] == 3'h0) && (&cs_hist);
	assign normal  = (timer_control_a[1:0] == 2'h0) && !timer_control_b[3];

	irq_gate_a: assert property (
		irq_req == (timer_flag_register[2:0] & timer_mask_register[2:0])
	) else $error("request not equal to flag and mask");
	count_write_a: assert property (
		cpu_wr.count |=> count_value == $past(cpu_wr.data)
	) else $error("count write lost");
	mask_write_a: assert property (
		cpu_wr.mask |=> timer_mask_register == {5'h00, $past(cpu_wr.data[2:0])}
	) else $error("mask write lost");
	cmp_write_a: assert property (
		cpu_wr.cmp_b |=> compare_value_b == $past(cpu_wr.data)
	) else $error("compare b write lost");
	stop_hold_a: assert property (
		stopped && !cpu_wr.count |=> $stable(count_value)
	) else $error("count moved while stopped");
	step_one_a: assert property (
		!cpu_wr.count |=> count_value == 8'h00 ||
		(8'(count_value - $past(count_value)) inside {8'h00, 8'h01, 8'hFF})
	) else $error("count moved by more than one");
	wrap_flag_a: assert property (
		normal && count_value == 8'hFF && !cpu_wr.count
		|=> count_value != 8'h00 || timer_flag_register[0]
	) else $error("wrap without overflow flag");
	match_flag_a: assert property (
		ind.match_a |-> timer_flag_register[1]
	) else $error("match a without its flag");
	spare_zero_a: assert property (
		timer_flag_register[7:3] == 5'h00 && timer_mask_register[7:3] == 5'h00
		&& timer_control_a[7:2] == 6'h00 && timer_control_b[7:4] == 4'h00
	) else $error("unused bits not zero");
endmodule : tcu_timer0_counter_checker

bind tcu_timer0_counter
	tcu_timer0_counter_checker i_tcu_timer0_counter_checker (
	.clk(clk), .nrst(nrst), .cpu_wr(cpu_wr), .irq_ack(irq_ack),
	.external_count_input(external_count_input), .count_value(count_value),
	.compare_value_a(compare_value_a), .compare_value_b(compare_value_b),
	.timer_control_a(timer_control_a), .timer_control_b(timer_control_b),
	.timer_flag_register(timer_flag_register),
	.timer_mask_register(timer_mask_register), .irq_req(irq_req), .ind(ind));

/* sim/tcu_timer0_counter_tb_top.sv */
`timescale 1ns/1ps
// Drives the counter core through its write strobes and checks its outputs.
module tcu_timer0_counter_tb_top;
	// Strobe selectors, in the bit order of the write struct.
	localparam logic [6:0] W_CNT = 7'h40;
	localparam logic [6:0] W_CMA = 7'h20;
	localparam logic [6:0] W_CMB = 7'h10;
	localparam logic [6:0] W_CTA = 7'h08;
	localparam logic [6:0] W_CTB = 7'h04;
	localparam logic [6:0] W_MSK = 7'h02;
	localparam logic [6:0] W_FLG = 7'h01;
	logic                 clk;
	logic                 nrst;
	tcu_pkg::tcu_cpu_wr_t cpu_wr;
	logic [2:0]           irq_ack;
	logic                 ext_in;
	logic [7:0]           count_value, compare_value_a, compare_value_b;
	logic [7:0]           timer_control_a, timer_control_b;
	logic [7:0]           timer_flag_register, timer_mask_register;
	logic [2:0]           irq_req;
	tcu_pkg::tcu_ind_t    ind;
	int                   miscompares, cmp_count;
	logic [7:0]           rb, base, top_seen;
	logic [6:0]           tsel[6] = '{W_CNT, W_CMA, W_CMB, W_CTA, W_CTB, W_MSK};
	logic [7:0]           tdat[6] = '{8'h5A, 8'hA5, 8'h3C, 8'hFF, 8'hF8, 8'hFF};
	logic [7:0]           texp[6] = '{8'h5A, 8'hA5, 8'h3C, 8'h03, 8'h08, 8'h07};
	int                   spans[5] = '{16, 64, 512, 2048, 2048};
	logic [7:0]           pexp[5] = '{8'h10, 8'h08, 8'h08, 8'h08, 8'h02};

	tcu_timer0_counter i_tcu_timer0_counter (
		.clk(clk), .nrst(nrst), .cpu_wr(cpu_wr), .irq_ack(irq_ack),
		.external_count_input(ext_in), .count_value(count_value),
		.compare_value_a(compare_value_a), .compare_value_b(compare_value_b),
		.timer_control_a(timer_control_a), .timer_control_b(timer_control_b),
		.timer_flag_register(timer_flag_register),
		.timer_mask_register(timer_mask_register), .irq_req(irq_req),
		.ind(ind));

	// Free-running 250 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [7:0] rd(input logic [6:0] sel);
		case (sel)
			W_CNT: return count_value;
			W_CMA: return compare_value_a;
			W_CMB: return compare_value_b;
			W_CTA: return timer_control_a;
			W_CTB: return timer_control_b;
			W_MSK: return timer_mask_register;
			default: return timer_flag_register;
		endcase
	endfunction : rd

	// Inputs always move 1 ns after a rising edge.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic chk(input string what, input logic [7:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	// One write pulse; the idle cycle after it keeps strobes from merging.
	task automatic wr(input logic [6:0] sel, input logic [7:0] d);
		cpu_wr = tcu_pkg::tcu_cpu_wr_t'({sel, d});
		cyc(1);
		rb = rd(sel);
		cpu_wr = '0;
		cyc(1);
	endtask : wr

	task automatic wait_cnt(input logic [7:0] v);
		for (int i = 0; i < 2000 && count_value !== v; i++) cyc(1);
		chk("count reached", v, count_value);
	endtask : wait_cnt

	task automatic wait_flag(input int b);
		for (int i = 0; i < 2000 && timer_flag_register[b] !== 1'b1; i++) cyc(1);
	endtask : wait_flag

	// Stop the source and let any tick already decoded drain away.
	task automatic halt();
		wr(W_CTB, 8'h00);
		cyc(3);
	endtask : halt

	task automatic wrap_up();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	// Main sequence.
	initial begin
		nrst = 1'b0;
		cpu_wr = '0;
		irq_ack = 3'h0;
		ext_in = 1'b0;
		miscompares = 0;
		cmp_count = 0;
		cyc(2);
		nrst = 1'b1;
		cyc(1);
		chk("reset", 8'h00, count_value | compare_value_a | compare_value_b |
			timer_control_a | timer_control_b | timer_flag_register |
			timer_mask_register);
		foreach (tsel[i]) begin
			wr(tsel[i], tdat[i]);
			chk("readback", texp[i], rb);
		end
		wr(W_CTA, 8'h00);
		wr(W_CTB, 8'h00);
		wr(W_CNT, 8'h10);
		cyc(20);
		chk("stopped count", 8'h10, count_value);
		// Ticks over a whole number of prescaler periods are exact.
		for (int i = 0; i < 5; i++) begin
			wr(W_CNT, 8'h00);
			wr(W_CTB, 8'(i + 1));
			cyc(10);
			base = count_value;
			cyc(spans[i]);
			chk("ticks", pexp[i], 8'(count_value - base));
			halt();
		end
		wr(W_FLG, 8'h07);
		wr(W_MSK, 8'h00);
		wr(W_CNT, 8'hF0);
		wr(W_CTB, 8'h01);
		wait_cnt(8'h00);
		chk("overflow", 8'h01, {7'h00, timer_flag_register[0]});
		chk("irq masked", 8'h00, {5'h00, irq_req});
		wr(W_MSK, 8'h01);
		chk("irq", 8'h01, {5'h00, irq_req});
		halt();
		wr(W_FLG, 8'h01);
		chk("flag clear", 8'h00, rb);
		wr(W_CMA, 8'h20);
		wr(W_CMB, 8'h30);
		wr(W_CNT, 8'h10);
		wr(W_CTB, 8'h01);
		wait_flag(1);
		chk("match a", 8'h21, count_value);
		wait_flag(2);
		chk("match b pulse", 8'h01, {7'h00, ind.match_b});
		chk("match b", 8'h31, count_value);
		wr(W_CNT, 8'h40);
		chk("write wins", 8'h40, rb);
		halt();
		irq_ack = 3'h2;
		cyc(1);
		irq_ack = 3'h0;
		chk("ack", 8'h04, timer_flag_register);
		wr(W_CTA, 8'h02);
		wr(W_CMA, 8'h05);
		wr(W_CNT, 8'h00);
		wr(W_CTB, 8'h01);
		top_seen = 8'h00;
		repeat (40) begin
			cyc(1);
			if (count_value > top_seen) top_seen = count_value;
		end
		chk("clear on match top", 8'h05, top_seen);
		wait_cnt(8'h05);
		chk("top hit", 8'h01, {7'h00, ind.top_hit});
		wait_cnt(8'h00);
		chk("bottom hit", 8'h01, {7'h00, ind.bottom_hit});
		halt();
		wr(W_CTA, 8'h01);
		wr(W_CNT, 8'hFC);
		wr(W_CTB, 8'h01);
		wait_cnt(8'hFF);
		cyc(1);
		chk("turn", 8'hFE, count_value);
		halt();
		wr(W_CTA, 8'h00);
		// Rising then falling edge of the pin, four pulses each.
		for (int k = 0; k < 2; k++) begin
			wr(W_CNT, 8'h00);
			wr(W_CTB, 8'(7 - k));
			repeat (4) begin
				ext_in = 1'b1;
				cyc(8);
				ext_in = 1'b0;
				cyc(8);
			end
			chk("external", 8'h04, count_value);
			halt();
		end
		// Fast PWM: a compare write waits in the buffer until the wrap.
		wr(W_CTA, 8'h03);
		wr(W_FLG, 8'h07);
		wr(W_CMA, 8'h08);
		chk("buffer", 8'h08, rb);
		wr(W_CNT, 8'h00);
		wr(W_CTB, 8'h01);
		wait_flag(1);
		chk("old compare", 8'h06, count_value);
		wr(W_FLG, 8'h02);
		wait_flag(1);
		chk("loaded compare", 8'h09, count_value);
		chk("pwm overflow", 8'h01, {7'h00, timer_flag_register[0]});
		halt();
		wrap_up();
	end

	// Watchdog well beyond the five and a half thousand or so cycles the tests need.
	initial begin
		#60000;
		miscompares++;
		wrap_up();
	end
endmodule : tcu_timer0_counter_tb_top
